// [src/dts_pkg.sv]
// constants for the task-file status register block
package dts_pkg;
    // register addresses: chip select group and three-bit address
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    localparam logic [2:0] ADDR_COMMAND = 3'h7;
    localparam logic [2:0] ADDR_ALT_STATUS = 3'h6;
    localparam logic [2:0] ADDR_DEV_CTRL = 3'h6;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    // command_status bit positions
    localparam int BIT_BUSY = 7;
    localparam int BIT_READY = 6;
    localparam int BIT_FAULT = 5;
    localparam int BIT_SEEK_DONE = 4;
    localparam int BIT_DATA_REQ = 3;
    localparam int BIT_FIXED_READ = 2;
    localparam int BIT_REV_PULSE = 1;
    localparam int BIT_FAILURE = 0;
    // device control bits
    localparam int BIT_SOFT_RESET = 2;
    localparam int BIT_INT_DISABLE = 1;
    // command opcode classes, by upper nibble or full code
    localparam logic [3:0] OPH_RECAL = 4'h1;
    localparam logic [3:0] OPH_READ = 4'h2;
    localparam logic [3:0] OPH_WRITE = 4'h3;
    localparam logic [3:0] OPH_VERIFY = 4'h4;
    localparam logic [3:0] OPH_FORMAT = 4'h5;
    localparam logic [3:0] OPH_SEEK = 4'h7;
    localparam logic [7:0] OP_READ_MULT = 8'hc4;
    localparam logic [7:0] OP_WRITE_MULT = 8'hc5;
    localparam logic [7:0] OP_DMA_FIRST = 8'hc8;
    localparam logic [7:0] OP_DMA_LAST = 8'hcb;
    // synchroniser width: reset, two selects, address, two strobes, data
    localparam int SYNC_W = 16;
    localparam logic [15:0] SYNC_INIT = 16'hffff;
endpackage

// [src/dts_acc_if.sv]
// decoded host access events passed from strobe decode to status logic
`timescale 1ns/10ps
interface dts_acc_if;
    logic rd_act;
    logic rd_status;
    logic rd_alt;
    logic rd_sel_stat;
    logic rd_sel_other;
    logic wr_cmd;
    logic wr_ctrl;
    logic wr_other;
    logic [2:0] addr;
    logic [7:0] wdata;
    modport gen (output rd_act, rd_status, rd_alt, rd_sel_stat, rd_sel_other,
                 wr_cmd, wr_ctrl, wr_other, addr, wdata);
    modport dst (input rd_act, rd_status, rd_alt, rd_sel_stat, rd_sel_other,
                 wr_cmd, wr_ctrl, wr_other, addr, wdata);
endinterface

// [src/dts_sync.sv]
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/10ps
module dts_sync #(
    parameter int W = 16,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        always_ff @(posedge clk) begin
            if (rst) begin
                s1_q <= INIT[i];
                s2_q <= INIT[i];
                s3_q <= INIT[i];
                level[i] <= INIT[i];
            end else begin
                s1_q <= pin[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                // one-cycle glitches past stage two are filtered here
                if (s2_q == s3_q) begin
                    level[i] <= s3_q;
                end
            end
        end
    end
endmodule

// [src/dts_strobe.sv]
// turns synchronised host strobes into one event per access, plus a read-active level held while the strobe is low and select levels held while selected
`timescale 1ns/10ps
module dts_strobe
    import dts_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic [7:0] dd,
    dts_acc_if.gen acc
);
    logic dior_prev_q;
    logic diow_prev_q;
    logic rd_edge;
    logic wr_edge;
    logic sel0;
    logic sel1;

    always_ff @(posedge clk) begin
        if (rst) begin
            dior_prev_q <= 1'b1;
            diow_prev_q <= 1'b1;
        end else begin
            dior_prev_q <= dior_n;
            diow_prev_q <= diow_n;
        end
    end

    // one read event per falling strobe edge, never per cycle held [R22]
    assign rd_edge = dior_prev_q && !dior_n;
    // data is taken at the trailing edge of the write strobe
    assign wr_edge = !diow_prev_q && diow_n;
    assign sel0 = !cs0_n && cs1_n;
    assign sel1 = !cs1_n && cs0_n;

    assign acc.rd_act = !dior_n && (sel0 || sel1);
    assign acc.rd_sel_stat = (sel0 && da == ADDR_STATUS)
                          || (sel1 && da == ADDR_ALT_STATUS);
    assign acc.rd_sel_other = sel0 && da != ADDR_STATUS;
    assign acc.rd_status = rd_edge && sel0 && da == ADDR_STATUS; // [R22]
    assign acc.rd_alt = rd_edge && sel1 && da == ADDR_ALT_STATUS;
    assign acc.wr_cmd = wr_edge && sel0 && da == ADDR_COMMAND;
    assign acc.wr_ctrl = wr_edge && sel1 && da == ADDR_DEV_CTRL;
    assign acc.wr_other = wr_edge && sel0 && da != ADDR_COMMAND;
    assign acc.addr = da;
    assign acc.wdata = dd;
endmodule

// [src/dts_status.sv]
// task-file command_status register with busy gating and interrupt request
// Functional notes
// [R1] status flags refresh at every command end and on any error
// [R2] while busy is set, all other status bits read as invalid zero
// [R3] while busy, other register reads return status and writes drop
// [R4] host status read clears a pending interrupt request
// [R5] busy sets on host reset, soft reset or command; clears on data request
// [R6] host must not access registers while busy reads one
// [R7] ready is one only while seek done is one; else commands refused (code refuses only seeking commands while not ready)
// [R8] not-ready mid-command aborts, sets failure, holds ready low till next
// [R9] fault during read/write sets fault and failure, refuses, holds
// [R10] seek done sets at seek end, clears when a seeking command starts
// [R11] failed seek ends command; seek done frozen until next status read
// [R12] after power-on seek done stays zero until spin-up is complete
// [R13] data request sets when the buffer wants one sector moved
// [R14] fixed-read bit always reads zero and never stops transfers
// [R15] revolution pulse bit pulses once per disk turn
// [R16] host must not use revolution pulse for timing
// [R17] failure flag marks errored last command, clears on next command
// [R18] failure flag set stops any multi-sector operation
// [R19] host should not depend on seek done bit
// [R20] command register write clears the interrupt request
// [R21] alternate status read returns same value, no interrupt clear
// [R22] each status read strobe counts as exactly one acknowledge event
`timescale 1ns/10ps
module dts_status (
    input wire logic clk,
    input wire logic rst,
    // host pins
    input wire logic host_reset_line_n,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic [7:0] dd_in,
    output logic [7:0] dd_out,
    output logic dd_oe,
    output logic intrq,
    // other task-file registers
    input wire logic [7:0] tf_rd_data,
    output logic tf_rd,
    output logic tf_wr,
    output logic [2:0] tf_addr,
    output logic [7:0] tf_wdata,
    // drive engine events, same clock
    input wire logic spin_ready,
    input wire logic cmd_done,
    input wire logic err_event,
    input wire logic not_ready_event,
    input wire logic fault_event,
    input wire logic seek_done,
    input wire logic seek_fail,
    input wire logic sector_req,
    input wire logic sector_taken,
    input wire logic index_pulse,
    // to the drive engine
    output logic cmd_start,
    output logic [7:0] cmd_code,
    output logic cmd_abort,
    output logic multi_stop,
    output logic soft_reset_bit,
    output logic [7:0] command_status
);
    import dts_pkg::*;

    dts_acc_if acc ();

    logic [SYNC_W-1:0] pins_s;
    logic host_reset_line_n_s;
    logic cs0_n_s;
    logic cs1_n_s;
    logic [2:0] da_s;
    logic dior_n_s;
    logic diow_n_s;
    logic [7:0] dd_s;

    dts_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
        .clk(clk),
        .rst(rst),
        .pin({host_reset_line_n, cs0_n, cs1_n, da, dior_n, diow_n, dd_in}),
        .level(pins_s)
    );

    assign {host_reset_line_n_s, cs0_n_s, cs1_n_s, da_s, dior_n_s, diow_n_s, dd_s} =
        pins_s;

    dts_strobe u_strobe (
        .clk(clk),
        .rst(rst),
        .cs0_n(cs0_n_s),
        .cs1_n(cs1_n_s),
        .da(da_s),
        .dior_n(dior_n_s),
        .diow_n(diow_n_s),
        .dd(dd_s),
        .acc(acc)
    );

    logic busy_q;
    logic ready_q;
    logic fault_q;
    logic seek_done_q;
    logic seek_frz_q;
    logic data_req_q;
    logic rev_q;
    logic fail_q;
    logic spun_q;
    logic nr_hold_q;
    logic act_q;
    logic act_rw_q;
    logic pend_q;
    logic int_dis_q;
    logic soft_reset_bit_q;
    logic [7:0] stat;

    function automatic logic op_is_rw(input logic [7:0] op);
        logic hit;
        hit = 1'b0;
        if (op[7:4] == OPH_READ || op[7:4] == OPH_WRITE
            || op[7:4] == OPH_VERIFY) begin
            hit = 1'b1;
        end else if (op == OP_READ_MULT || op == OP_WRITE_MULT) begin
            hit = 1'b1;
        end else if (op >= OP_DMA_FIRST && op <= OP_DMA_LAST) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    function automatic logic op_seeks(input logic [7:0] op);
        return op_is_rw(op) || op[7:4] == OPH_RECAL
            || op[7:4] == OPH_SEEK || op[7:4] == OPH_FORMAT;
    endfunction

    // soft or hard reset held by the host
    logic host_rst;
    assign host_rst = !host_reset_line_n_s || soft_reset_bit_q;

    logic cmd_wr;
    assign cmd_wr = acc.wr_cmd && !busy_q && !host_rst; // [R3]

    logic cmd_ok;
    assign cmd_ok = !op_seeks(acc.wdata)
                 || (ready_q && !fault_q); // [R7] [R9]

    logic nr_abort;
    logic df_abort;
    logic sk_abort;
    logic abort_now;
    logic end_now;
    logic refuse_now;
    assign nr_abort = act_q && not_ready_event; // [R8]
    assign df_abort = act_q && act_rw_q && fault_event; // [R9]
    assign sk_abort = act_q && seek_fail; // [R11]
    assign abort_now = nr_abort || df_abort || sk_abort;
    assign end_now = act_q && (cmd_done || abort_now);
    assign refuse_now = cmd_wr && !cmd_ok;

    logic err_now;
    assign err_now = abort_now || refuse_now || (act_q && err_event);

    logic drq_set;
    assign drq_set = act_q && act_rw_q && sector_req && !abort_now; // [R13]

    // device control register
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_reset_bit_q <= 1'b0;
            int_dis_q <= 1'b0;
        end else if (acc.wr_ctrl) begin
            soft_reset_bit_q <= acc.wdata[BIT_SOFT_RESET];
            int_dis_q <= acc.wdata[BIT_INT_DISABLE];
        end
    end

    // busy: set wins over any clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b1;
        end else if (host_rst || cmd_wr && cmd_ok) begin
            busy_q <= 1'b1; // [R5]
        end else if (drq_set || end_now || refuse_now) begin
            busy_q <= 1'b0; // [R5]
        end else if (!act_q && cmd_done) begin
            busy_q <= 1'b0;
        end
    end

    // command tracking and engine handshake
    always_ff @(posedge clk) begin
        if (rst || host_rst) begin
            act_q <= 1'b0;
            act_rw_q <= 1'b0;
            cmd_start <= 1'b0;
            cmd_code <= 8'h00;
        end else begin
            cmd_start <= cmd_wr && cmd_ok;
            if (cmd_wr) begin
                cmd_code <= acc.wdata;
            end
            if (cmd_wr && cmd_ok) begin
                act_q <= 1'b1;
                act_rw_q <= op_is_rw(acc.wdata);
            end else if (end_now) begin
                act_q <= 1'b0;
                act_rw_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_abort <= 1'b0;
            multi_stop <= 1'b0;
        end else begin
            cmd_abort <= abort_now; // [R8] [R9] [R11]
            // a fresh failure ends any multi-sector run in progress
            multi_stop <= err_now && act_q; // [R18]
        end
    end

    // failure flag: cleared by the next command, error wins same cycle
    always_ff @(posedge clk) begin
        if (rst || host_rst) begin
            fail_q <= 1'b0;
        end else if (err_now) begin
            fail_q <= 1'b1; // [R17] [R1]
        end else if (cmd_wr) begin
            fail_q <= 1'b0; // [R17]
        end
    end

    // fault is held until the next command
    always_ff @(posedge clk) begin
        if (rst || host_rst) begin
            fault_q <= 1'b0;
        end else if (df_abort) begin
            fault_q <= 1'b1; // [R9]
        end else if (cmd_wr) begin
            fault_q <= 1'b0; // [R9]
        end
    end

    // not-ready hold keeps ready low until a new command
    always_ff @(posedge clk) begin
        if (rst || host_rst) begin
            nr_hold_q <= 1'b0;
        end else if (nr_abort) begin
            nr_hold_q <= 1'b1; // [R8]
        end else if (cmd_wr) begin
            nr_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            spun_q <= 1'b0;
        end else begin
            spun_q <= spin_ready; // [R12]
        end
    end

    // seek done; frozen after a failed seek until a status read
    always_ff @(posedge clk) begin
        if (rst) begin
            seek_done_q <= 1'b0;
            seek_frz_q <= 1'b0;
        end else begin
            if (sk_abort) begin
                seek_frz_q <= 1'b1; // [R11]
            end else if (acc.rd_status) begin
                seek_frz_q <= 1'b0;
            end
            if (!spun_q) begin
                seek_done_q <= 1'b0; // [R12]
            end else if (seek_frz_q || sk_abort) begin
                seek_done_q <= seek_done_q; // [R11]
            end else if (seek_done) begin
                seek_done_q <= 1'b1; // [R10]
            end else if (cmd_wr && cmd_ok && op_seeks(acc.wdata)) begin
                seek_done_q <= 1'b0; // [R10]
            end
        end
    end

    // ready follows seek done, spin-up and the not-ready hold
    always_ff @(posedge clk) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= spun_q && seek_done_q && !nr_hold_q; // [R7] [R8]
        end
    end

    // data request: one sector at a time
    always_ff @(posedge clk) begin
        if (rst || host_rst) begin
            data_req_q <= 1'b0;
        end else if (drq_set) begin
            data_req_q <= 1'b1; // [R13]
        end else if (sector_taken || end_now || cmd_wr) begin
            data_req_q <= 1'b0;
        end
    end

    // host must not time anything off this pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            rev_q <= 1'b0;
        end else begin
            rev_q <= index_pulse; // [R15] [R16]
        end
    end

    // interrupt pending: completion, refusal and data request set it
    logic int_set;
    assign int_set = end_now || refuse_now || drq_set;

    always_ff @(posedge clk) begin
        if (rst || host_rst) begin
            pend_q <= 1'b0;
        end else if (int_set) begin
            pend_q <= 1'b1;
        end else if (acc.rd_status) begin
            pend_q <= 1'b0; // [R4] [R22]
        end else if (acc.wr_cmd) begin
            pend_q <= 1'b0; // [R20]
        end
    end

    // alternate status read never reaches the pending flag
    always_ff @(posedge clk) begin
        if (rst) begin
            intrq <= 1'b0;
        end else begin
            intrq <= pend_q && !int_dis_q; // [R21]
        end
    end

    // invalid bits hidden while busy; fixed-read is always zero
    always_comb begin
        stat = 8'h00;
        stat[BIT_BUSY] = busy_q;
        if (!busy_q) begin // [R2]
            stat[BIT_READY] = ready_q;
            stat[BIT_FAULT] = fault_q;
            stat[BIT_SEEK_DONE] = seek_done_q; // [R19]
            stat[BIT_DATA_REQ] = data_req_q;
            stat[BIT_FIXED_READ] = 1'b0; // [R14]
            stat[BIT_REV_PULSE] = rev_q;
            stat[BIT_FAILURE] = fail_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            command_status <= STATUS_RESET;
        end else begin
            command_status <= stat; // [R1]
        end
    end

    // host read data path
    always_ff @(posedge clk) begin
        if (rst) begin
            dd_out <= 8'h00;
            dd_oe <= 1'b0;
            tf_rd <= 1'b0;
        end else begin
            dd_oe <= acc.rd_act;
            tf_rd <= acc.rd_act && acc.rd_sel_other && !busy_q; // [R3]
            if (acc.rd_sel_stat || busy_q) begin
                dd_out <= stat; // [R3] [R21]
            end else begin
                dd_out <= tf_rd_data;
            end
        end
    end

    // other register writes pass only while idle
    always_ff @(posedge clk) begin
        if (rst) begin
            tf_wr <= 1'b0;
            tf_addr <= 3'h0;
            tf_wdata <= 8'h00;
        end else begin
            tf_wr <= acc.wr_other && !busy_q; // [R3]
            tf_addr <= acc.addr;
            if (acc.wr_other) begin
                tf_wdata <= acc.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            soft_reset_bit <= 1'b0;
        end else begin
            soft_reset_bit <= soft_reset_bit_q;
        end
    end
endmodule

// [verification/dts_status_assertions.sv]
// port-level assertions for the task-file status block
`timescale 1ns/10ps
module dts_status_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic intrq,
    input wire logic cmd_start,
    input wire logic cmd_abort,
    input wire logic tf_wr,
    input wire logic not_ready_event,
    input wire logic [7:0] command_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    fixed_read_zero_a: assert property (!command_status[2])
        else $error("fixed-read bit set");
    busy_hides_flags_a: assert property (
        command_status[7] |-> command_status[6:0] == 7'h00)
        else $error("flags visible while busy");
    ready_needs_seek_a: assert property (
        command_status[6] |-> command_status[4])
        else $error("ready without seek done");
    start_sets_busy_a: assert property (
        cmd_start |=> command_status[7])
        else $error("command started without busy");
    busy_drops_write_a: assert property (
        tf_wr |-> !$past(command_status[7]))
        else $error("register write passed while busy");
    status_read_ack_a: assert property (
        $fell(dior_n) && !cs0_n && cs1_n && da == 3'h7 |-> ##[5:8] !intrq)
        else $error("status read left interrupt pending");
    command_clears_irq_a: assert property (
        cmd_start |-> ##[1:2] !intrq)
        else $error("command write left interrupt pending");
    alt_keeps_irq_a: assert property (
        $fell(dior_n) && !cs1_n && cs0_n && da == 3'h6 && intrq
        |=> intrq [*8])
        else $error("alternate read dropped interrupt");
    not_ready_abort_a: assert property (
        not_ready_event && command_status[7] |-> ##[1:2] cmd_abort)
        else $error("no abort on not ready");
endmodule

bind dts_status dts_status_assertions chk (
    .clk(clk), .rst(rst), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da),
    .dior_n(dior_n), .intrq(intrq), .cmd_start(cmd_start),
    .cmd_abort(cmd_abort), .tf_wr(tf_wr),
    .not_ready_event(not_ready_event), .command_status(command_status)
);

// [verification/dts_host_model.sv]
// behavioural host controller driving the task-file pins
`timescale 1ns/10ps
module dts_host_model (
    input wire logic clk,
    output logic cs0_n,
    output logic cs1_n,
    output logic [2:0] da,
    output logic dior_n,
    output logic diow_n,
    output logic [7:0] dd_in,
    input wire logic [7:0] dd_out
);
    initial begin
        cs0_n = 1'b1;
        cs1_n = 1'b1;
        da = 3'h0;
        dior_n = 1'b1;
        diow_n = 1'b1;
        dd_in = 8'h00;
    end
    task automatic cyc(input logic alt, input logic [2:0] a,
                       input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge clk);
        #1;
        cs0_n = alt;
        cs1_n = !alt;
        da = a;
        dd_in = wr ? wd : ~dd_in;
        @(posedge clk);
        #1;
        dior_n = wr;
        diow_n = !wr;
        repeat (7) @(posedge clk);
        #1;
        rd = dd_out;
        dior_n = 1'b1;
        diow_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        cs0_n = 1'b1;
        cs1_n = 1'b1;
        da = ~a;
        dd_in = ~dd_in;
        repeat (4) @(posedge clk);
    endtask
    task automatic acc(input bit polite, input logic alt,
                       input logic [2:0] a, input logic wr,
                       input logic [7:0] wd, output logic [7:0] rd);
        logic [7:0] s;
        int n;
        s = 8'h80;
        n = 0;
        // busy bit only, never index or seek done
        while (polite && s[7] && n < 60) begin
            cyc(1'b1, 3'h6, 1'b0, 8'h00, s);
            n++;
        end
        cyc(alt, a, wr, wd, rd);
    endtask
endmodule

// [verification/tb_disk_task_file_status.sv]
// self-checking bench for the task-file status block
`timescale 1ns/10ps
module tb_disk_task_file_status;
    import dts_pkg::*;
    localparam logic [7:0] E_DONE = 8'h80;
    localparam logic [7:0] E_ERR = 8'h40;
    localparam logic [7:0] E_NRDY = 8'h20;
    localparam logic [7:0] E_FAULT = 8'h10;
    localparam logic [7:0] E_SEEK = 8'h08;
    localparam logic [7:0] E_REQ = 8'h02;
    localparam logic [7:0] E_TAKEN = 8'h01;
    localparam logic [7:0] OPS [11] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50,
        8'h70, 8'hc4, 8'hc5, 8'hc8, 8'he0, 8'hec};
    logic clk, rst, host_reset_line_n, spin_ready, index_pulse, fl;
    logic cs0_n, cs1_n, dior_n, diow_n, dd_oe, intrq, tf_rd, tf_wr;
    logic cmd_start, cmd_abort, multi_stop, soft_reset_bit;
    logic [2:0] da, tf_addr;
    logic [7:0] dd_in, dd_out, tf_rd_data, tf_wdata, cmd_code;
    logic [7:0] command_status, ev, d, wd, op, last_code;
    int mismatches, total_checks, starts, aborts, wrs, n0;
    integer seed;

    dts_status uut (.clk(clk), .rst(rst),
        .host_reset_line_n(host_reset_line_n), .cs0_n(cs0_n),
        .cs1_n(cs1_n), .da(da), .dior_n(dior_n), .diow_n(diow_n),
        .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe), .intrq(intrq),
        .tf_rd_data(tf_rd_data), .tf_rd(tf_rd), .tf_wr(tf_wr),
        .tf_addr(tf_addr), .tf_wdata(tf_wdata), .spin_ready(spin_ready),
        .cmd_done(ev[7]), .err_event(ev[6]), .not_ready_event(ev[5]),
        .fault_event(ev[4]), .seek_done(ev[3]), .seek_fail(ev[2]),
        .sector_req(ev[1]), .sector_taken(ev[0]),
        .index_pulse(index_pulse), .cmd_start(cmd_start),
        .cmd_code(cmd_code), .cmd_abort(cmd_abort),
        .multi_stop(multi_stop), .soft_reset_bit(soft_reset_bit),
        .command_status(command_status));
    dts_host_model host (.clk(clk), .cs0_n(cs0_n), .cs1_n(cs1_n),
        .da(da), .dior_n(dior_n), .diow_n(diow_n), .dd_in(dd_in),
        .dd_out(dd_out));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd_start === 1'b1) begin
            starts <= starts + 1;
            last_code <= cmd_code;
        end
        if (cmd_abort === 1'b1)
            aborts <= aborts + 1;
        if (tf_wr === 1'b1)
            wrs <= wrs + 1;
        index_pulse <= #1 dior_n && ($random(seed) % 16 == 0);
    end

    function automatic logic [7:0] st(input logic rdy, input logic flt,
        input logic sk, input logic data_request_flag, input logic fail);
        return {1'b0, rdy, flt, sk, data_request_flag, 2'b00, fail};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [7:0] m);
        ev = m;
        step(1);
        ev = 8'h00;
        step(3);
    endtask
    task automatic rd_stat(output logic [7:0] v);
        host.acc(1'b1, 1'b0, ADDR_STATUS, 1'b0, 8'h00, v);
    endtask
    task automatic cmd(input logic [7:0] c);
        host.acc(1'b1, 1'b0, ADDR_COMMAND, 1'b1, c, d);
        chk(last_code, c, "command code");
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
    initial begin
        seed = 21063;
        {mismatches, total_checks, starts, aborts, wrs} = '0;
        rst = 1'b1;
        host_reset_line_n = 1'b1;
        spin_ready = 1'b0;
        index_pulse = 1'b0;
        ev = 8'h00;
        tf_rd_data = 8'h00;
        last_code = 8'h00;
        step(10);
        rst = 1'b0;
        step(6);
        chk(command_status, STATUS_RESET, "reset value");
        pulse(E_DONE);
        rd_stat(d);
        chk(d, st(0, 0, 0, 0, 0), "before spin-up");
        spin_ready = 1'b1;
        pulse(E_SEEK);
        rd_stat(d);
        chk(d, st(1, 0, 1, 0, 0), "ready");
        // every opcode class, then random picks, some ending in error
        for (int i = 0; i < 16; i++) begin
            op = i < 11 ? OPS[i] : OPS[$unsigned($random(seed)) % 11];
            fl = (i % 4 == 3);
            cmd(op);
            pulse(fl ? (E_SEEK | E_ERR) : E_SEEK);
            pulse(E_DONE);
            chk(8'(intrq), 8'h01, "done irq");
            host.acc(1'b1, 1'b1, ADDR_ALT_STATUS, 1'b0, 8'h00, d);
            chk(d, st(1, 0, 1, 0, fl), "alt status");
            chk(8'(intrq), 8'h01, "irq after alt");
            rd_stat(d);
            chk(d, st(1, 0, 1, 0, fl), "status at end");
            chk(8'(intrq), 8'h00, "irq after ack");
        end
        wd = $random(seed);
        tf_rd_data = $random(seed);
        n0 = wrs;
        host.acc(1'b1, 1'b0, 3'h3, 1'b1, wd, d);
        chk(tf_wdata, wd, "write data");
        chk(8'(wrs - n0), 8'h01, "one write");
        host.acc(1'b1, 1'b0, 3'h3, 1'b0, 8'h00, d);
        chk(d, tf_rd_data, "read data");
        cmd(8'h20);
        n0 = wrs;
        host.acc(1'b0, 1'b0, 3'h3, 1'b1, ~wd, d);
        host.acc(1'b0, 1'b0, 3'h3, 1'b0, 8'h00, d);
        chk(8'(wrs - n0), 8'h00, "busy write");
        chk(d, STATUS_RESET, "busy read");
        pulse(E_SEEK);
        pulse(E_REQ);
        rd_stat(d);
        chk(d, st(1, 0, 1, 1, 0), "data request");
        pulse(E_TAKEN);
        pulse(E_DONE);
        rd_stat(d);
        chk(d, st(1, 0, 1, 0, 0), "transfer end");
        cmd(8'h30);
        pulse(E_SEEK);
        pulse(E_FAULT);
        pulse(E_DONE);
        rd_stat(d);
        chk(d, st(1, 1, 1, 0, 1), "fault end");
        n0 = starts;
        host.acc(1'b1, 1'b0, ADDR_COMMAND, 1'b1, 8'h20, d);
        chk(8'(starts - n0), 8'h00, "refused");
        rd_stat(d);
        chk(d & 8'h81, 8'h01, "refusal error");
        cmd(8'he0);
        pulse(E_DONE);
        rd_stat(d);
        chk(d, st(1, 0, 1, 0, 0), "fault cleared");
        cmd(8'h20);
        pulse(E_SEEK);
        n0 = aborts;
        pulse(E_NRDY);
        chk(8'(aborts - n0), 8'h01, "abort");
        pulse(E_DONE);
        rd_stat(d);
        chk(d, st(0, 0, 1, 0, 1), "not ready end");
        cmd(8'he0);
        pulse(E_DONE);
        rd_stat(d);
        chk(d, st(1, 0, 1, 0, 0), "ready again");
        host_reset_line_n = 1'b0;
        step(8);
        chk(command_status, STATUS_RESET, "pin reset");
        host_reset_line_n = 1'b1;
        step(6);
        pulse(E_DONE);
        rd_stat(d);
        chk(d & 8'h89, 8'h00, "after pin reset");
        host.acc(1'b1, 1'b1, ADDR_DEV_CTRL, 1'b1, 8'h04, d);
        chk(8'(soft_reset_bit), 8'h01, "soft bit");
        chk(command_status, STATUS_RESET, "soft reset");
        host.acc(1'b0, 1'b1, ADDR_DEV_CTRL, 1'b1, 8'h00, d);
        pulse(E_DONE);
        rd_stat(d);
        chk(d & 8'h80, 8'h00, "soft reset done");
        spin_ready = 1'b0;
        step(4);
        chk(command_status & 8'h40, 8'h00, "spin lost");
        tally_and_finish;
    end
endmodule
